// ===== core/erb_logger.sv
// Error report bank logger: per-error enable mask, status log, collision rules.
// Assumes a single clock, Avalon-MM slave software side and same-clock error reporters.
// Behaviour
// - Control register holds 64 enable flags gating exception signalling per error.
// - Errors are logged regardless of their enable flag.
// - Writes to unimplemented enable bits are dropped silently.
// - Status is cleared by writing zeros; nonzero writes fault and leave it.
// - Bits 15:0 hold architectural code, 31:16 model-specific code.
// - Firmware-first: info in 36:32, bit 37 marks firmware edit; else 37:32.
// - With corrected signalling, bits 52:38 count corrected errors until cleared.
// - Bit 52 is a sticky counter overflow indicator.
// - Bits 56:53 architectural only with threshold status (colour 54:53 is written regardless); 56:55 reserved without recovery.
// - With recovery support, bit 56 flags recoverable signal, bit 55 action required.
// - Bits 54:53 give threshold colour for corrected errors.
// - Bit 57 flags possibly corrupted processor context.
// - Bit 58 marks address info valid, bit 59 misc info valid.
// - Bit 60 records that the error's enable flag was set.
// - Bit 61 set when the error was uncorrected.
// - Overflow bit 62 set when an error arrives while valid; software clears.
// - Enabled beats disabled, uncorrected beats corrected, never over valid uncorrected.
// - With corrected signalling, corrected collisions may leave overflow unchanged.
// - Valid bit 63 set on capture, cleared only by software.
// - Yellow outranks green or untracked; uncorrected outranks all colours.
// - Overwrite takes all new fields except overflow and, with corrected signalling, count; a kept entry changes only in those two.
// - Unmonitored structures always log the untracked colour code.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module erb_logger #(
  parameter logic [63:0] CTL_IMPL = 64'hffff_ffff_ffff_ffff,
  parameter logic [31:0] CAP_VALUE = 32'h0300_0c00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [erb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic err_valid,
  input wire logic [5:0] err_index,
  input wire logic [15:0] err_arch_code,
  input wire logic [15:0] err_model_code,
  input wire logic [5:0] err_other_info,
  input wire logic err_uncorrected,
  input wire logic err_pcc,
  input wire logic err_address_info_valid_flag,
  input wire logic err_misc_info_valid_flag,
  input wire logic err_monitored,
  input wire logic err_yellow,
  input wire logic err_recoverable_sig,
  input wire logic err_action_required,
  input wire logic fw_edit,
  output logic machine_check_exception,
  output logic gp_fault
);
  import erb_pkg::*;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [63:0] ctl;
  logic [63:0] sts;
  logic [63:0] next_sts;
  logic [31:0] fault_cnt;
  wire logic ack = ~avs_waitrequest;
  wire logic req = (avs_read | avs_write) & ~ack;
  wire logic wr = avs_write & req;
  wire logic rd = avs_read & req;
  wire logic sel_ctl_lo = (avs_address == OFF_CTL_LO);
  wire logic sel_ctl_hi = (avs_address == OFF_CTL_HI);
  wire logic sel_sts_lo = (avs_address == OFF_STS_LO);
  wire logic sel_sts_hi = (avs_address == OFF_STS_HI);
  wire logic [31:0] bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic cmci_p = CAP_VALUE[CAP_CMCI];
  wire logic tes_p = CAP_VALUE[CAP_TES];
  wire logic ser_p = CAP_VALUE[CAP_SER];
  wire logic emc_p = CAP_VALUE[CAP_EMC];

  wire logic sts_wr = wr & (sel_sts_lo | sel_sts_hi);
  wire logic sts_bad = sts_wr & ((avs_writedata & bemask) != 32'h0);
  wire logic sts_clr_lo = sts_wr & ~sts_bad & sel_sts_lo;
  wire logic sts_clr_hi = sts_wr & ~sts_bad & sel_sts_hi;

  // enable mask write, unimplemented bits kept
  wire logic [31:0] ctl_lo_new = (ctl[31:0] & ~(bemask & CTL_IMPL[31:0]))
                                 | (avs_writedata & bemask & CTL_IMPL[31:0]);
  wire logic [31:0] ctl_hi_new = (ctl[63:32] & ~(bemask & CTL_IMPL[63:32]))
                                 | (avs_writedata & bemask & CTL_IMPL[63:32]);

  wire logic [31:0] rd_mux = sel_ctl_lo ? ctl[31:0] :
                             sel_ctl_hi ? ctl[63:32] :
                             sel_sts_lo ? sts[31:0] :
                             sel_sts_hi ? sts[63:32] :
                             (avs_address == OFF_CAP) ? CAP_VALUE :
                             (avs_address == OFF_FAULT) ? fault_cnt : RD_UNMAPPED;

  // ==========================================================
  // New event record
  // ==========================================================
  // enable captured from the mask
  wire logic ev_en = ctl[err_index];
  wire logic [1:0] ev_col = ~err_monitored ? COL_NONE :
                            (err_yellow ? COL_YELLOW : COL_GREEN);
  // Log as left by a same-cycle software clear, so a new event is never lost to it
  wire logic [63:0] sts_eff = {sts_clr_hi ? 32'h0 : sts[63:32],
                               sts_clr_lo ? 32'h0 : sts[31:0]};
  wire logic [1:0] old_col = sts_eff[B_COL_HI:B_COL_LO];
  wire logic old_val = sts_eff[B_VAL];
  wire logic old_uc = sts_eff[B_UC];
  wire logic old_en = sts_eff[B_EN];
  wire logic ev_corr = err_valid & ~err_uncorrected;

  wire logic replace = ~old_val |
                       (err_uncorrected ? ~old_uc :
                       (~old_uc & ((ev_en & ~old_en) |
                        ((ev_en == old_en) & ~(old_col == COL_YELLOW & ev_col != COL_YELLOW)))));

  // corrected counter with sticky top bit
  wire logic [13:0] cnt_low = sts_eff[B_CNT_HI-1:B_CNT_LO];
  wire logic cnt_wrap = (cnt_low == 14'h3fff);
  wire logic [14:0] cnt_next = {sts_eff[B_CNT_HI] | cnt_wrap, cnt_low + 14'h1};

  function automatic logic [63:0] build_rec(input logic [14:0] cnt);
    logic [63:0] r;
    r = 64'h0;
    r[15:0] = err_arch_code;
    r[31:16] = err_model_code;
    r[36:32] = err_other_info[4:0];
    r[B_FW_EDIT] = emc_p ? fw_edit : err_other_info[5];
    r[B_CNT_HI:B_CNT_LO] = cnt;
    // colour field, written whether or not threshold status is present
    r[B_COL_HI:B_COL_LO] = ev_col;
    // recovery flags, reserved without recovery support
    r[B_SIG] = tes_p & ser_p & err_recoverable_sig;
    r[B_AR] = tes_p & ser_p & err_action_required;
    r[B_PCC] = err_pcc;
    r[B_ADDRESS_INFO_VALID_FLAG] = err_address_info_valid_flag;
    r[B_MISC_INFO_VALID_FLAG] = err_misc_info_valid_flag;
    r[B_EN] = ev_en;
    r[B_UC] = err_uncorrected;
    r[B_VAL] = 1'b1;
    return r;
  endfunction

  wire logic [14:0] cnt_keep = cmci_p ? (ev_corr ? cnt_next : sts_eff[B_CNT_HI:B_CNT_LO])
                                      : {9'h0, err_other_info};
  wire logic over_set = old_val & ~(cmci_p & ev_corr & ~old_uc);

  always_comb begin
    next_sts = sts_eff;
    if (err_valid) begin
      if (replace) begin
        next_sts = build_rec(cmci_p ? (old_val ? cnt_keep :
                    (ev_corr ? 15'h1 : 15'h0)) : {9'h0, err_other_info});
      end else if (cmci_p) begin
        next_sts[B_CNT_HI:B_CNT_LO] = cnt_keep;
      end
      if (over_set) begin
        next_sts[B_OVER] = 1'b1;
      end
      if (replace & old_val & ~over_set) begin
        next_sts[B_OVER] = sts_eff[B_OVER];
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= CTL_RST;
      sts <= STS_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      gp_fault <= 1'b0;
      fault_cnt <= 32'h0;
      machine_check_exception <= 1'b0;
    end else begin
      avs_waitrequest <= ~req;
      sts <= next_sts;
      gp_fault <= sts_bad;
      if (sts_bad) begin
        fault_cnt <= fault_cnt + 32'h1;
      end
      if (rd) begin
        avs_readdata <= rd_mux;
      end
      if (wr & sel_ctl_lo) begin
        ctl[31:0] <= ctl_lo_new;
      end
      if (wr & sel_ctl_hi) begin
        ctl[63:32] <= ctl_hi_new;
      end
      machine_check_exception <= err_valid & ev_en & err_uncorrected;
    end
  end


  // ==========================================================
  // Checks
  // ==========================================================
  chk_gp_noupdate: assert property (@(posedge clk) disable iff (!rst_n)
    sts_bad & ~err_valid |=> sts == $past(sts))
    else $error("Faulting status write changed the log");
  chk_val_set: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid |=> sts[B_VAL])
    else $error("Valid not set after capture");
  chk_over_set: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & old_val & err_uncorrected & ~sts_wr |=> sts[B_OVER])
    else $error("Overflow not set on collision");
  chk_uc_kept: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & old_val & old_uc & ~sts_wr |=> sts[31:0] == $past(sts[31:0]))
    else $error("Valid uncorrected entry was overwritten");
  chk_log_always: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ~old_val & ~ev_en & ~sts_wr |=> sts[15:0] == $past(err_arch_code))
    else $error("Disabled error not logged");
  chk_en_bit: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ~old_val & ~sts_wr |=> sts[B_EN] == $past(ev_en))
    else $error("Enable record wrong");
  chk_yellow_kept: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & old_val & ~old_uc & old_col == COL_YELLOW & ~err_uncorrected & ~sts_wr
    |=> sts[B_COL_HI:B_COL_LO] == COL_YELLOW)
    else $error("Yellow replaced by lower colour");
  chk_untracked: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ~old_val & ~err_monitored & ~sts_wr |=> sts[B_COL_HI:B_COL_LO] == COL_NONE)
    else $error("Unmonitored event posted a colour");
  chk_cnt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    cmci_p & sts[B_CNT_HI] & ~sts_clr_hi |=> sts[B_CNT_HI])
    else $error("Counter overflow bit not sticky");
  chk_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
    req |=> ~avs_waitrequest)
    else $error("Bus answer late");
  cov_collide: cover property (@(posedge clk) err_valid & old_val);
  cov_fault: cover property (@(posedge clk) sts_bad);
  cov_clear: cover property (@(posedge clk) sts_clr_hi & sts[B_VAL]);
  cov_uc_over: cover property (@(posedge clk) err_valid & err_uncorrected & old_val & ~old_uc);
  cov_kept: cover property (@(posedge clk) err_valid & old_val & ~replace);

  // ==========================================================
  // Mask, signalling and fault checks
  // ==========================================================
  chk_mce_raise: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ev_en & err_uncorrected |=> machine_check_exception)
    else $error("Enabled uncorrected error not signalled");

  chk_mce_masked: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ~ev_en |=> ~machine_check_exception)
    else $error("Disabled error signalled");

  chk_ctl_impl: assert property (@(posedge clk) disable iff (!rst_n)
    wr & sel_ctl_hi
    |=> (ctl[63:32] & ~CTL_IMPL[63:32]) == $past(ctl[63:32] & ~CTL_IMPL[63:32]))
    else $error("Unimplemented enable bit changed");

  chk_gp_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    sts_bad |=> gp_fault)
    else $error("Nonzero status write did not fault");

  chk_gp_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    ~sts_bad |=> ~gp_fault)
    else $error("Fault raised without a nonzero status write");

  chk_fault_count: assert property (@(posedge clk) disable iff (!rst_n)
    sts_bad |=> fault_cnt == $past(fault_cnt) + 32'h1)
    else $error("Fault not counted");

  chk_zero_clear: assert property (@(posedge clk) disable iff (!rst_n)
    sts_clr_hi & ~err_valid |=> sts[63:32] == 32'h0)
    else $error("Zero write did not clear the upper log word");

  // ==========================================================
  // Record content checks
  // ==========================================================
  chk_codes: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace |=> sts[31:0] == $past({err_model_code, err_arch_code}))
    else $error("Error codes not logged");

  chk_fw_split: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace
    |=> sts[36:32] == $past(err_other_info[4:0])
    && sts[B_FW_EDIT] == (emc_p ? $past(fw_edit) : $past(err_other_info[5])))
    else $error("Information field split wrong");

  chk_cnt_first: assert property (@(posedge clk) disable iff (!rst_n)
    cmci_p & ev_corr & ~old_val & ~sts_wr |=> sts[B_CNT_HI:B_CNT_LO] == 15'h1)
    else $error("First corrected error not counted");

  chk_cnt_step: assert property (@(posedge clk) disable iff (!rst_n)
    cmci_p & ev_corr & old_val & ~sts_wr
    |=> sts[B_CNT_HI-1:B_CNT_LO] == $past(cnt_low) + 14'h1)
    else $error("Corrected error count did not step");

  chk_cnt_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    cmci_p & ev_corr & old_val & (cnt_low == 14'h3fff) & ~sts_wr |=> sts[B_CNT_HI])
    else $error("Counter overflow not flagged");

  chk_recov_flags: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace & tes_p & ser_p
    |=> sts[B_SIG] == $past(err_recoverable_sig) && sts[B_AR] == $past(err_action_required))
    else $error("Recovery flags not logged");

  chk_colour: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace & err_monitored & ~err_uncorrected
    |=> sts[B_COL_HI:B_COL_LO] == ($past(err_yellow) ? COL_YELLOW : COL_GREEN))
    else $error("Threshold colour wrong");

  chk_col_legal: assert property (@(posedge clk) disable iff (!rst_n)
    sts[B_VAL] & ~sts[B_UC] |-> sts[B_COL_HI:B_COL_LO] != 2'h3)
    else $error("Reserved colour code logged");

  chk_ctx_flags: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace
    |=> sts[B_PCC] == $past(err_pcc) && sts[B_ADDRESS_INFO_VALID_FLAG] == $past(err_address_info_valid_flag)
    && sts[B_MISC_INFO_VALID_FLAG] == $past(err_misc_info_valid_flag))
    else $error("Context or info valid flags wrong");

  chk_uc_bit: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & replace |=> sts[B_UC] == $past(err_uncorrected))
    else $error("Uncorrected flag wrong");

  // ==========================================================
  // Collision and hold checks
  // ==========================================================
  chk_over_hold: assert property (@(posedge clk) disable iff (!rst_n)
    sts[B_OVER] & ~sts_clr_hi |=> sts[B_OVER])
    else $error("Overflow cleared by hardware");

  chk_uc_wins: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & err_uncorrected & old_val & ~old_uc & ~sts_wr
    |=> sts[B_UC] && sts[15:0] == $past(err_arch_code))
    else $error("Uncorrected error did not replace corrected entry");

  chk_en_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ev_corr & old_val & ~old_uc & ev_en & ~old_en & ~sts_wr
    |=> sts[B_EN] && sts[15:0] == $past(err_arch_code))
    else $error("Enabled error did not replace disabled entry");

  chk_corr_noover: assert property (@(posedge clk) disable iff (!rst_n)
    cmci_p & ev_corr & old_val & ~old_uc & ~sts[B_OVER] & ~sts_wr |=> ~sts[B_OVER])
    else $error("Corrected collision set overflow");

  chk_val_hold: assert property (@(posedge clk) disable iff (!rst_n)
    sts[B_VAL] & ~sts_clr_hi |=> sts[B_VAL])
    else $error("Valid cleared by hardware");

  chk_yellow_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ev_corr & old_val & ~old_uc & (ev_en == old_en) & (ev_col == COL_YELLOW) & ~sts_wr
    |=> sts[B_COL_HI:B_COL_LO] == COL_YELLOW)
    else $error("Yellow event did not replace lower colour");

  chk_kept_whole: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid & ~replace & ~sts_wr
    |=> sts[B_UC:B_COL_LO] == $past(sts[B_UC:B_COL_LO])
    && sts[B_FW_EDIT:0] == $past(sts[B_FW_EDIT:0]))
    else $error("Kept entry was altered");

endmodule // erb_logger

// ===== core/erb_pkg.sv
// Package for the error report bank logger: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
package erb_pkg;
  localparam int unsigned ADDR_W = 5;
  // Byte offsets of the 32-bit register words
  localparam logic [4:0] OFF_CTL_LO = 5'h00;
  localparam logic [4:0] OFF_CTL_HI = 5'h04;
  localparam logic [4:0] OFF_STS_LO = 5'h08;
  localparam logic [4:0] OFF_STS_HI = 5'h0c;
  localparam logic [4:0] OFF_CAP = 5'h10;
  localparam logic [4:0] OFF_FAULT = 5'h14;
  // Status log field positions
  localparam int unsigned B_FW_EDIT = 37;
  localparam int unsigned B_CNT_LO = 38;
  localparam int unsigned B_CNT_HI = 52;
  localparam int unsigned B_COL_LO = 53;
  localparam int unsigned B_COL_HI = 54;
  localparam int unsigned B_AR = 55;
  localparam int unsigned B_SIG = 56;
  localparam int unsigned B_PCC = 57;
  localparam int unsigned B_ADDRESS_INFO_VALID_FLAG = 58;
  localparam int unsigned B_MISC_INFO_VALID_FLAG = 59;
  localparam int unsigned B_EN = 60;
  localparam int unsigned B_UC = 61;
  localparam int unsigned B_OVER = 62;
  localparam int unsigned B_VAL = 63;
  // Capability bit positions in the capability word
  localparam int unsigned CAP_CMCI = 10;
  localparam int unsigned CAP_TES = 11;
  localparam int unsigned CAP_SER = 24;
  localparam int unsigned CAP_EMC = 25;
  // Threshold colour codes
  localparam logic [1:0] COL_NONE = 2'h0;
  localparam logic [1:0] COL_GREEN = 2'h1;
  localparam logic [1:0] COL_YELLOW = 2'h2;
  // Reset values
  localparam logic [63:0] CTL_RST = 64'h0;
  localparam logic [63:0] STS_RST = 64'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0;
endpackage

// ===== sim/erb_err_src.sv
// Error reporter model: posts one error report per call as a one-cycle pulse.
// Assumes the logger samples the report on the rising clock edge.
`timescale 1ns/10ps
module erb_err_src (
  input wire logic clk,
  output logic err_valid,
  output logic [5:0] err_index,
  output logic [15:0] err_arch_code,
  output logic [15:0] err_model_code,
  output logic [5:0] err_other_info,
  output logic err_uncorrected,
  output logic err_pcc,
  output logic err_address_info_valid_flag,
  output logic err_misc_info_valid_flag,
  output logic err_monitored,
  output logic err_yellow,
  output logic err_recoverable_sig,
  output logic err_action_required,
  output logic fw_edit
);
  logic [52:0] fields = '0;
  initial err_valid = 1'b0;
  assign {err_index, err_arch_code, err_model_code, err_other_info, err_uncorrected, err_pcc,
    err_address_info_valid_flag, err_misc_info_valid_flag, err_monitored, err_yellow, err_recoverable_sig,
    err_action_required, fw_edit} = fields;
  task automatic send(input logic [5:0] idx, input logic [15:0] arch, input logic [15:0] mdl,
    input logic [5:0] info, input logic [8:0] fl);
    @(posedge clk);
    err_valid <= 1'b1;
    fields <= {idx, arch, mdl, info, fl};
    @(posedge clk);
    err_valid <= 1'b0;
    // Released qualifiers show the inverse so stale values cannot pass
    fields <= ~{idx, arch, mdl, info, fl};
  endtask
endmodule // erb_err_src

// ===== sim/error_report_bank_logger_bench.sv
// Bench for the error report bank logger: register tasks plus error reporter model.
// Assumes a 32-bit Avalon-MM slave with one wait state and a 50 MHz clock.
`timescale 1ns/10ps
module error_report_bank_logger_bench;
  import erb_pkg::*;
  localparam logic [63:0] IMPL = 64'h0000_ffff_ffff_ffff;
  localparam logic [31:0] CAP = 32'h0300_0c00;
  localparam logic [31:0] CNTCOL = 32'h007f_ffc0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd, ucv;
  logic avs_waitrequest, machine_check_exception, gp_fault;
  logic err_valid, err_uncorrected, err_pcc, err_address_info_valid_flag, err_misc_info_valid_flag, err_monitored, err_yellow;
  logic err_recoverable_sig, err_action_required, fw_edit;
  logic [5:0] err_index, err_other_info;
  logic [15:0] err_arch_code, err_model_code;
  int error_cnt = 0;
  int num_checks = 0;
  int mce_n = 0;
  int gp_n = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (machine_check_exception === 1'b1) mce_n++;
    if (gp_fault === 1'b1) gp_n++;
  end
  erb_logger #(.CTL_IMPL(IMPL), .CAP_VALUE(CAP)) dut_u (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .err_valid, .err_index, .err_arch_code, .err_model_code, .err_other_info, .err_uncorrected,
    .err_pcc, .err_address_info_valid_flag, .err_misc_info_valid_flag, .err_monitored, .err_yellow, .err_recoverable_sig,
    .err_action_required, .fw_edit, .machine_check_exception, .gp_fault);
  erb_err_src src_u (.clk, .err_valid, .err_index, .err_arch_code, .err_model_code,
    .err_other_info, .err_uncorrected, .err_pcc, .err_address_info_valid_flag, .err_misc_info_valid_flag, .err_monitored,
    .err_yellow, .err_recoverable_sig, .err_action_required, .fw_edit);
  function automatic logic [31:0] hb(input int unsigned b);
    return 32'h1 << (b - 32);
  endfunction
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is seen low at a rising edge, data taken there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: bus access timed out", $time);
      end_sim();
    end else begin
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(i * 4), '0);
      chk(rd, 32'h0); // reset values
    end
    bus(1'b0, OFF_CAP, '0);
    chk(rd, CAP); // capability word
    bus(1'b0, 5'h18, '0);
    chk(rd, RD_UNMAPPED); // unmapped reads zero
    $display("test reset done");
    bus(1'b1, OFF_CTL_HI, 32'hffff_ffff);
    bus(1'b0, OFF_CTL_HI, '0);
    chk(rd, IMPL[63:32]); // unimplemented bits dropped
    bus(1'b1, OFF_CTL_LO, 32'h0000_0001);
    bus(1'b0, OFF_CTL_LO, '0);
    chk(rd, 32'h0000_0001); // enable mask
    $display("test control done");
    src_u.send(6'h01, 16'h1234, 16'h5678, 6'h0a, 9'h010);
    bus(1'b0, OFF_STS_LO, '0);
    chk(rd, 32'h5678_1234); // error codes
    bus(1'b0, OFF_STS_HI, '0);
    chk(rd, hb(B_VAL) | hb(B_COL_LO) | hb(B_CNT_LO) | 32'h0a); // disabled still logged
    src_u.send(6'h00, 16'h1111, 16'h2222, 6'h03, 9'h019);
    bus(1'b0, OFF_STS_LO, '0);
    chk(rd, 32'h2222_1111); // enabled yellow replaces disabled green
    bus(1'b0, OFF_STS_HI, '0);
    ucv = hb(B_VAL) | hb(B_EN) | hb(B_COL_HI) | hb(B_FW_EDIT) | 32'h03;
    chk(rd, ucv | hb(B_CNT_LO + 1)); // count without overflow
    src_u.send(6'h01, 16'h3333, 16'h4444, 6'h04, 9'h010);
    bus(1'b0, OFF_STS_HI, '0);
    chk(rd, ucv | hb(B_CNT_LO + 1) | hb(B_CNT_LO)); // kept entry intact but count stepped
    $display("test corrected done");
    src_u.send(6'h00, 16'haaaa, 16'hbbbb, 6'h00, 9'h1e6);
    bus(1'b0, OFF_STS_HI, '0);
    ucv = hb(B_VAL) | hb(B_OVER) | hb(B_UC) | hb(B_EN) | hb(B_MISC_INFO_VALID_FLAG) | hb(B_ADDRESS_INFO_VALID_FLAG);
    ucv = ucv | hb(B_PCC) | hb(B_SIG) | hb(B_AR);
    chk(rd & ~CNTCOL, ucv); // overflow on uncorrected arrival
    src_u.send(6'h02, 16'hcccc, 16'hdddd, 6'h00, 9'h100);
    bus(1'b0, OFF_STS_LO, '0);
    chk(rd, 32'hbbbb_aaaa); // valid uncorrected kept
    chk(32'(mce_n), 32'h1); // only enabled error signals
    $display("test uncorrected done");
    bus(1'b1, OFF_STS_HI, 32'h0000_0001);
    bus(1'b0, OFF_STS_HI, '0);
    chk(rd & ~CNTCOL, ucv); // faulted write leaves log
    chk(32'(gp_n), 32'h1); // nonzero write faults
    bus(1'b0, OFF_FAULT, '0);
    chk(rd, 32'h1); // fault counted once
    bus(1'b1, OFF_STS_LO, '0);
    bus(1'b1, OFF_STS_HI, '0);
    bus(1'b0, OFF_STS_LO, '0);
    chk(rd, 32'h0); // software clear
    bus(1'b0, OFF_STS_HI, '0);
    chk(rd, 32'h0); // overflow cleared by software
    chk(32'(gp_n), 32'h1); // zero write no fault
    src_u.send(6'h00, 16'h0001, 16'h0002, 6'h01, 9'h008);
    bus(1'b0, OFF_STS_HI, '0);
    chk(rd, hb(B_VAL) | hb(B_EN) | hb(B_CNT_LO) | 32'h01); // unmonitored colour
    $display("test clear done");
    end_sim();
  end
endmodule // error_report_bank_logger_bench
